// ---- hdl/dbw_pkg.sv ----
// package: register indices, field positions, cause codes and monitor carrier
package dbw_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRIG_DATA = 8'h16;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_STOP_VEC = 8'h18;
  localparam logic [7:0] IDX_SCRATCH = 8'h20;
  localparam logic [7:0] IDX_IB_ADDR = 8'h30;
  localparam logic [7:0] IDX_IB_CTRL = 8'h40;
  localparam logic [7:0] IDX_DW_ADDR1 = 8'h50;
  localparam logic [7:0] IDX_DW_ADDR2 = 8'h60;
  localparam logic [7:0] IDX_DW_CTRL = 8'h70;
  localparam logic [7:0] IDX_RW_MASK = 8'h80;
  localparam logic [7:0] IDX_RW_VALUE = 8'h90;
  localparam logic [7:0] IDX_RW_CTRL = 8'h9C;
  // control field positions
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_SENSE_BIT = 1;
  localparam int CTL_LOAD_BIT = 2;
  localparam int CTL_THR_LSB = 16;
  // writable bits of the control registers; the rest read as zero
  localparam logic [31:0] IB_CTRL_WMASK = 32'h00FF0003;
  localparam logic [31:0] DW_CTRL_WMASK = 32'h00FF0007;
  localparam logic [31:0] RW_CTRL_WMASK = 32'h00FF0003;
  localparam logic [31:0] STOP_WMASK = 32'h000000FF;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  // cause register layout
  localparam int CAUSE_NUM_LSB = 16;
  localparam int CAUSE_THR_LSB = 8;
  // cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_IBREAK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;
  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  // what one thread does in one cycle, as seen by the watch logic
  typedef struct packed {
    logic [2:0] thread;       // issuing thread number
    logic pc_valid;           // an instruction issues at pc
    logic [31:0] pc;
    logic mem_valid;          // a memory operation issues
    logic mem_load;           // 1 load, 0 store
    logic [31:0] mem_addr;    // effective address
    logic res_valid;          // a resource operation issues
    logic [31:0] res_id;      // resource identifier
  } dbw_core_mon_type;

  // debug interrupt record handed to the debug-interrupt logic
  typedef struct packed {
    logic [2:0] cause;
    logic [1:0] num;
    logic [7:0] thread;
  } dbw_trig_type;
endpackage

// ---- hdl/dbw_top.sv ----
// debug breakpoint and watchpoint unit with AHB-Lite register slave
// How it works
// - data watch trigger loads trigger data register with effective address
// - resource watch trigger loads all 32 bits with resource identifier
// - 8-bit stop vector halts set threads whenever not in debug mode
// - eight scratch words shared between bus and tile configuration port
// - four instruction breakpoints with own address, fire on PC compare
// - instruction control bit 1 picks equal or not-equal compare
// - control bit 0 enables each breakpoint, resets to zero
// - bits 23:16 enable each thread per breakpoint, reset to zero
// - four data watchpoints with first and second address registers
// - data control bit 1 picks A and B, or A or B
// - data control bit 2 lets loads trigger, resets to zero
// - four resource watchpoints with mask and value registers
// - resource control bit 1 picks condition A or condition B
// - cause code 3 instruction, 4 data, 5 resource
// - record number of firing unit, lowest one wins
// - record 8-bit number of the thread that caused the interrupt
`timescale 1ns/100ps
module dbw_top
  import dbw_pkg::*;
(
  input wire logic mclk_i,                   // tile clock, 20 MHz
  input wire logic rst_n_i,                  // async reset, active low
  input wire logic hsel_i,                   // AHB slave select
  input wire logic [31:0] haddr_i,           // AHB address
  input wire logic [1:0] htrans_i,           // AHB transfer type
  input wire logic hwrite_i,                 // AHB write
  input wire logic [2:0] hsize_i,            // AHB size, word only
  input wire logic hready_i,                 // AHB bus ready
  input wire logic [31:0] hwdata_i,          // AHB write data
  output logic [31:0] hrdata_o,              // AHB read data
  output logic hreadyout_o,                  // AHB slave ready
  output logic hresp_o,                      // AHB response
  input wire logic cfg_we_i,                 // tile config scratch write
  input wire logic [2:0] cfg_idx_i,          // tile config scratch index
  input wire logic [31:0] cfg_wdata_i,       // tile config write data
  output logic [31:0] cfg_rdata_o,           // tile config read data
  input wire dbw_core_mon_type mon_i,        // monitored thread activity
  input wire logic debug_mode_i,             // processor is in debug mode
  output logic dbg_irq_o,                    // debug interrupt request pulse
  output dbw_trig_type trig_o,               // cause of last interrupt
  output logic [7:0] thread_stop_o           // threads held stopped
);

  // operating notes for whoever integrates this block:
  // - the bus slave never stalls; an address phase is taken at any edge
  //   with hsel, hready and a NONSEQ or SEQ transfer type
  // - read data is fetched in the address phase and held in a flop, so
  //   hrdata is stable for the whole data phase at no extra wait state
  // - a write lands at the edge that closes its data phase; a read that
  //   follows at once sees the masked write data through the forward path
  // - the forward path applies the same write masks as the registers,
  //   so reserved and read-only bits never leak back for one cycle
  // - the cause word at index 0x15 is read-only; writes to it are lost
  // - unmapped indices read as zero and ignore writes, without error
  // - a hit is seen in the cycle the monitor shows it and reported as a
  //   one-cycle pulse at the next edge, together with the cause record
  // - several hits in one cycle: instruction first, then data, then
  //   resource; inside one kind the lowest unit number is reported
  // - a hardware capture of the trigger data wins over software, since
  //   losing a trigger address would hide the event from the debugger
  // - debug mode both mutes every watch unit and frees the stop lines,
  //   so debug code itself never trips a breakpoint or gets held
  // - stop lines lag the stop vector by one cycle; the core must not
  //   issue for a stopped thread from the cycle it sees the line high
  // - the tile configuration port shares the scratch words; a bus write
  //   to the same cycle wins, the other writer must retry if it cares
  // - the thread number is three bits wide here and zero-extended into
  //   the eight-bit record field

  // register storage
  logic [31:0] scratch_ff [8];
  logic [31:0] ib_addr_ff [4];
  logic [31:0] ib_ctrl_ff [4];
  logic [31:0] dw_addr1_ff [4];
  logic [31:0] dw_addr2_ff [4];
  logic [31:0] dw_ctrl_ff [4];
  logic [31:0] rw_mask_ff [4];
  logic [31:0] rw_value_ff [4];
  logic [31:0] rw_ctrl_ff [4];
  logic [31:0] trig_data_ff;
  logic [7:0] stop_vec_ff;

  // bus pipeline state
  logic wr_pend_ff;
  logic [7:0] wr_idx_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] cfg_rdata_ff;
  logic hready_ff;
  logic hresp_ff;

  // trigger outputs
  logic dbg_irq_ff;
  dbw_trig_type trig_ff;
  logic [7:0] thread_stop_ff;

  // hit vectors
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  // lowest set bit wins when several units fire together
  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[0]) begin
      r = 2'h0;
    end else if (v[1]) begin
      r = 2'h1;
    end else if (v[2]) begin
      r = 2'h2;
    end else if (v[3]) begin
      r = 2'h3;
    end
    return r;
  endfunction

  // index falls in a group of four starting at base
  function automatic logic in_quad(input logic [7:0] idx, input logic [7:0] base);
    return idx[7:2] == base[7:2];
  endfunction

  // enable and thread gate common to every unit
  function automatic logic armed(input logic [31:0] ctl, input logic [2:0] thr);
    logic [7:0] thr_en;
    thr_en = ctl[CTL_THR_LSB +: 8];
    return ctl[CTL_EN_BIT] & thr_en[thr];
  endfunction

  // bits that a bus write really stores; the read forward must agree
  function automatic logic [31:0] wmask(input logic [7:0] idx);
    logic [31:0] m;
    m = WORD_RESET;
    if (idx == IDX_TRIG_DATA) begin
      m = '1;
    end else if (idx == IDX_STOP_VEC) begin
      m = STOP_WMASK;
    end else if (idx[7:3] == IDX_SCRATCH[7:3]) begin
      m = '1;
    end else if (in_quad(idx, IDX_IB_ADDR) || in_quad(idx, IDX_DW_ADDR1)) begin
      m = '1;
    end else if (in_quad(idx, IDX_DW_ADDR2) || in_quad(idx, IDX_RW_MASK)) begin
      m = '1;
    end else if (in_quad(idx, IDX_RW_VALUE)) begin
      m = '1;
    end else if (in_quad(idx, IDX_IB_CTRL)) begin
      m = IB_CTRL_WMASK;
    end else if (in_quad(idx, IDX_DW_CTRL)) begin
      m = DW_CTRL_WMASK;
    end else if (in_quad(idx, IDX_RW_CTRL)) begin
      m = RW_CTRL_WMASK;
    end
    return m;
  endfunction

  // address phase accepted on a selected word transfer
  logic addr_ok;
  logic [7:0] a_idx;
  assign addr_ok = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
  assign a_idx = haddr_i[9:2];

  // watch comparisons; nothing fires while the processor is in debug mode
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic pc_eq;
      logic cond_a;
      logic cond_b;
      logic res_a;
      pc_eq = mon_i.pc == ib_addr_ff[i];
      ib_hit[i] = ~debug_mode_i & mon_i.pc_valid & armed(ib_ctrl_ff[i], mon_i.thread)
                  & (ib_ctrl_ff[i][CTL_SENSE_BIT] ? ~pc_eq : pc_eq);
      cond_a = mon_i.mem_addr == dw_addr1_ff[i];
      cond_b = mon_i.mem_addr == dw_addr2_ff[i];
      dw_hit[i] = ~debug_mode_i & mon_i.mem_valid & armed(dw_ctrl_ff[i], mon_i.thread)
                  & (~mon_i.mem_load | dw_ctrl_ff[i][CTL_LOAD_BIT])
                  & (dw_ctrl_ff[i][CTL_SENSE_BIT] ? (cond_a | cond_b)
                                                  : (cond_a & cond_b));
      res_a = (mon_i.res_id & rw_mask_ff[i]) == (rw_value_ff[i] & rw_mask_ff[i]);
      rw_hit[i] = ~debug_mode_i & mon_i.res_valid & armed(rw_ctrl_ff[i], mon_i.thread)
                  & (rw_ctrl_ff[i][CTL_SENSE_BIT] ? ~res_a : res_a);
    end
  end

  // read mux for the address-phase index; the capture flop forwards a pending write
  always_comb begin
    nxt_rdata = WORD_RESET;
    if (a_idx == IDX_TRIG_DATA) begin
      nxt_rdata = trig_data_ff;
    end else if (a_idx == IDX_CAUSE) begin
      nxt_rdata = {14'h0000, trig_ff.num, trig_ff.thread, 5'h00, trig_ff.cause};
    end else if (a_idx == IDX_STOP_VEC) begin
      nxt_rdata = {24'h000000, stop_vec_ff};
    end else if (a_idx[7:3] == IDX_SCRATCH[7:3]) begin
      nxt_rdata = scratch_ff[a_idx[2:0]];
    end else if (in_quad(a_idx, IDX_IB_ADDR)) begin
      nxt_rdata = ib_addr_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_IB_CTRL)) begin
      nxt_rdata = ib_ctrl_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_DW_ADDR1)) begin
      nxt_rdata = dw_addr1_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_DW_ADDR2)) begin
      nxt_rdata = dw_addr2_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_DW_CTRL)) begin
      nxt_rdata = dw_ctrl_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_RW_MASK)) begin
      nxt_rdata = rw_mask_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_RW_VALUE)) begin
      nxt_rdata = rw_value_ff[a_idx[1:0]];
    end else if (in_quad(a_idx, IDX_RW_CTRL)) begin
      nxt_rdata = rw_ctrl_ff[a_idx[1:0]];
    end
  end

  // address phase capture; read data is fetched here so hrdata is a flop
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
      hrdata_ff <= WORD_RESET;
    end else if (hready_i) begin
      wr_pend_ff <= addr_ok & hwrite_i;
      wr_idx_ff <= a_idx;
      // back-to-back write then read of the same word sees the new data
      if (wr_pend_ff && wr_idx_ff == a_idx) begin
        hrdata_ff <= hwdata_i & wmask(wr_idx_ff);
      end else begin
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  // write strobes for the data phase
  logic wr_go;
  assign wr_go = wr_pend_ff;

  // scratch words: bus write wins over a same-cycle tile config write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 8; i++) begin
        scratch_ff[i] <= WORD_RESET;
      end
      cfg_rdata_ff <= WORD_RESET;
    end else begin
      if (wr_go && wr_idx_ff[7:3] == IDX_SCRATCH[7:3]) begin
        scratch_ff[wr_idx_ff[2:0]] <= hwdata_i;
      end else if (cfg_we_i) begin
        scratch_ff[cfg_idx_i] <= cfg_wdata_i;
      end
      cfg_rdata_ff <= scratch_ff[cfg_idx_i];
    end
  end

  // breakpoint and watchpoint address and control words
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        ib_addr_ff[i] <= WORD_RESET;
        ib_ctrl_ff[i] <= WORD_RESET;
        dw_addr1_ff[i] <= WORD_RESET;
        dw_addr2_ff[i] <= WORD_RESET;
        dw_ctrl_ff[i] <= WORD_RESET;
        rw_mask_ff[i] <= WORD_RESET;
        rw_value_ff[i] <= WORD_RESET;
        rw_ctrl_ff[i] <= WORD_RESET;
      end
    end else if (wr_go) begin
      if (in_quad(wr_idx_ff, IDX_IB_ADDR)) begin
        ib_addr_ff[wr_idx_ff[1:0]] <= hwdata_i;
      end
      if (in_quad(wr_idx_ff, IDX_IB_CTRL)) begin
        ib_ctrl_ff[wr_idx_ff[1:0]] <= hwdata_i & IB_CTRL_WMASK;
      end
      if (in_quad(wr_idx_ff, IDX_DW_ADDR1)) begin
        dw_addr1_ff[wr_idx_ff[1:0]] <= hwdata_i;
      end
      if (in_quad(wr_idx_ff, IDX_DW_ADDR2)) begin
        dw_addr2_ff[wr_idx_ff[1:0]] <= hwdata_i;
      end
      if (in_quad(wr_idx_ff, IDX_DW_CTRL)) begin
        dw_ctrl_ff[wr_idx_ff[1:0]] <= hwdata_i & DW_CTRL_WMASK;
      end
      if (in_quad(wr_idx_ff, IDX_RW_MASK)) begin
        rw_mask_ff[wr_idx_ff[1:0]] <= hwdata_i;
      end
      if (in_quad(wr_idx_ff, IDX_RW_VALUE)) begin
        rw_value_ff[wr_idx_ff[1:0]] <= hwdata_i;
      end
      if (in_quad(wr_idx_ff, IDX_RW_CTRL)) begin
        rw_ctrl_ff[wr_idx_ff[1:0]] <= hwdata_i & RW_CTRL_WMASK;
      end
    end
  end

  // stop vector and the stop lines it drives; debug mode releases them
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_vec_ff <= 8'h00;
      thread_stop_ff <= 8'h00;
    end else begin
      if (wr_go && wr_idx_ff == IDX_STOP_VEC) begin
        stop_vec_ff <= hwdata_i[7:0];
      end
      thread_stop_ff <= debug_mode_i ? 8'h00 : stop_vec_ff;
    end
  end

  // trigger capture; instruction beats data beats resource in one cycle.
  // a hardware capture wins over a same-cycle software write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_data_ff <= WORD_RESET;
      dbg_irq_ff <= 1'b0;
      trig_ff <= '{cause: CAUSE_NONE, num: 2'h0, thread: 8'h00};
    end else begin
      dbg_irq_ff <= |{ib_hit, dw_hit, rw_hit};
      if (|ib_hit) begin
        trig_ff.cause <= CAUSE_IBREAK;
        trig_ff.num <= lowest(ib_hit);
        trig_ff.thread <= {5'h00, mon_i.thread};
      end else if (|dw_hit) begin
        trig_ff.cause <= CAUSE_DWATCH;
        trig_ff.num <= lowest(dw_hit);
        trig_ff.thread <= {5'h00, mon_i.thread};
        trig_data_ff <= mon_i.mem_addr;
      end else if (|rw_hit) begin
        trig_ff.cause <= CAUSE_RWATCH;
        trig_ff.num <= lowest(rw_hit);
        trig_ff.thread <= {5'h00, mon_i.thread};
        trig_data_ff <= mon_i.res_id;
      end else if (wr_go && wr_idx_ff == IDX_TRIG_DATA) begin
        trig_data_ff <= hwdata_i;
      end
    end
  end

  // slave never stalls and always answers okay, still driven from flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hready_ff <= 1'b1;
      hresp_ff <= HRESP_OKAY;
    end else begin
      hready_ff <= 1'b1;
      hresp_ff <= HRESP_OKAY;
    end
  end

  // outputs straight from flops
  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o = hresp_ff;
  assign cfg_rdata_o = cfg_rdata_ff;
  assign dbg_irq_o = dbg_irq_ff;
  assign trig_o = trig_ff;
  assign thread_stop_o = thread_stop_ff;

endmodule // dbw_top

// ---- tb/dbw_chk.sv ----
// port assertions for the debug breakpoint and watch unit
`timescale 1ns/100ps
module dbw_chk
  import dbw_pkg::*;
(
  input wire logic mclk_i,              // tile clock
  input wire logic rst_n_i,             // async reset, active low
  input wire logic hreadyout_o,         // slave ready
  input wire logic hresp_o,             // slave response
  input wire dbw_core_mon_type mon_i,   // thread activity
  input wire logic debug_mode_i,        // debug mode level
  input wire logic dbg_irq_o,           // interrupt pulse
  input wire dbw_trig_type trig_o,      // interrupt record
  input wire logic [7:0] thread_stop_o  // stopped threads
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // one kind of activity alone, so the cause code is known
  sequence s_pc_only;
    mon_i.pc_valid && !mon_i.mem_valid && !mon_i.res_valid;
  endsequence
  sequence s_mem_only;
    mon_i.mem_valid && !mon_i.pc_valid && !mon_i.res_valid;
  endsequence
  sequence s_res_only;
    mon_i.res_valid && !mon_i.pc_valid && !mon_i.mem_valid;
  endsequence
  bus_okay_a: assert property (hreadyout_o && hresp_o == HRESP_OKAY)
    else $error("bus answer not ready and okay");
  ib_cause_a: assert property (s_pc_only ##1 dbg_irq_o |-> trig_o.cause == CAUSE_IBREAK)
    else $error("instruction hit with wrong cause");
  dw_cause_a: assert property (s_mem_only ##1 dbg_irq_o |-> trig_o.cause == CAUSE_DWATCH)
    else $error("data hit with wrong cause");
  rw_cause_a: assert property (s_res_only ##1 dbg_irq_o |-> trig_o.cause == CAUSE_RWATCH)
    else $error("resource hit with wrong cause");
  irq_thread_a: assert property (dbg_irq_o |-> trig_o.thread == {5'h0, $past(mon_i.thread)})
    else $error("interrupt thread number wrong");
  stop_release_a: assert property (debug_mode_i |=> thread_stop_o == 8'h00)
    else $error("threads held while in debug mode");
  debug_quiet_a: assert property (debug_mode_i |=> !dbg_irq_o)
    else $error("interrupt raised in debug mode");
  idle_quiet_a: assert property (!(mon_i.pc_valid || mon_i.mem_valid || mon_i.res_valid)
    |=> !dbg_irq_o)
    else $error("interrupt without any activity");
  trig_hold_a: assert property (!dbg_irq_o |-> $stable(trig_o))
    else $error("record changed without interrupt");
endmodule // dbw_chk

// ---- tb/dbw_core_model.sv ----
// behavioural model of the issuing threads and debug-mode control
`timescale 1ns/100ps
module dbw_core_model
  import dbw_pkg::*;
(
  input wire logic mclk_i,              // tile clock
  input wire logic [7:0] thread_stop_i, // threads held stopped
  output dbw_core_mon_type mon_o,       // thread activity
  output logic debug_mode_o             // in debug mode
);
  initial mon_o = '0;
  initial debug_mode_o = 1'b0;
  // one operation for one cycle; a held thread stays silent
  task automatic issue(input dbw_core_mon_type m);
    dbw_core_mon_type idle;
    idle = ~m;
    idle.pc_valid = 1'b0;
    idle.mem_valid = 1'b0;
    idle.res_valid = 1'b0;
    @(posedge mclk_i);
    if (thread_stop_i[m.thread] !== 1'b1) begin
      mon_o <= m;
    end
    @(posedge mclk_i);
    mon_o <= idle; // dead fields change so stale values never match
  endtask
  task automatic set_mode(input logic v);
    @(posedge mclk_i);
    debug_mode_o <= v;
  endtask
endmodule // dbw_core_model

// ---- tb/dbw_tb_top.sv ----
// self-checking bench for the debug breakpoint and watch unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module dbw_tb_top;
  import dbw_pkg::*;
  int fails = 0;
  int n_tests = 0;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, cfg_wdata = '0, hrdata, cfg_rdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] cfg_idx = '0;
  logic hsel = 1'b0, hwrite = 1'b0, cfg_we = 1'b0, hready, hresp, dbg_mode, irq;
  logic [7:0] stop;
  dbw_core_mon_type mon;
  dbw_trig_type trig;
  always #25 mclk_i = ~mclk_i;
  dbw_top i_dbw_top(.mclk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .cfg_we_i(cfg_we),
    .cfg_idx_i(cfg_idx), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .mon_i(mon),
    .debug_mode_i(dbg_mode), .dbg_irq_o(irq), .trig_o(trig), .thread_stop_o(stop));
  dbw_core_model i_dbw_core_model(.mclk_i, .thread_stop_i(stop), .mon_o(mon),
    .debug_mode_o(dbg_mode));
  // single word transfer; each phase held until hready is seen at a rising edge
  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'h0};
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
    bus(1'b1, ix, wd);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 32'h0);
    `CHK(nm, e, rd)
  endtask
  // k: 0 instruction, 1 store, 2 load, 3 resource
  function automatic dbw_core_mon_type mk(input logic [2:0] t, input int k, input logic [31:0] v);
    mk = '0;
    mk.thread = t;
    mk.pc = v;
    mk.mem_addr = v;
    mk.res_id = v;
    mk.pc_valid = (k == 0);
    mk.mem_valid = (k == 1 || k == 2);
    mk.mem_load = (k == 2);
    mk.res_valid = (k == 3);
  endfunction
  task automatic hit(input dbw_core_mon_type m, input logic f, input logic [2:0] c,
    input logic [1:0] n);
    i_dbw_core_model.issue(m);
    @(negedge mclk_i);
    `CHK("irq", f, irq)
    if (f) `CHK("trig", {c, n, 5'h0, m.thread}, trig)
  endtask
  task automatic t_reset();
    `CHK("stop", 8'h00, stop)
    `CHK("trig", 13'h0, trig)
    for (int i = 0; i < 4; i++) begin
      chk_reg("ib_ctrl", IDX_IB_CTRL + 8'(i), WORD_RESET);
      chk_reg("dw_ctrl", IDX_DW_CTRL + 8'(i), WORD_RESET);
      chk_reg("rw_ctrl", IDX_RW_CTRL + 8'(i), WORD_RESET);
    end
    chk_reg("unmapped", 8'h10, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++) wr(IDX_SCRATCH + 8'(i), {24'hA5C300, 8'(i)});
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      cfg_idx <= 3'(i);
      @(posedge mclk_i);
      @(negedge mclk_i);
      `CHK("cfg_rd", {24'hA5C300, 8'(i)}, cfg_rdata)
    end
    @(posedge mclk_i);
    cfg_we <= 1'b1;
    cfg_idx <= 3'h7;
    cfg_wdata <= 32'h1234ABCD;
    @(posedge mclk_i);
    cfg_we <= 1'b0;
    chk_reg("scratch", IDX_SCRATCH + 8'h7, 32'h1234ABCD);
    wr(IDX_IB_CTRL, 32'hFFFFFFFF);
    chk_reg("ib_ctrl", IDX_IB_CTRL, IB_CTRL_WMASK);
    wr(IDX_IB_CTRL, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_ibreak();
    for (int n = 0; n < 4; n++) begin
      wr(IDX_IB_ADDR + 8'(n), 32'h400 + n);
      wr(IDX_IB_CTRL + 8'(n), 32'h00040001);
      hit(mk(3'h2, 0, 32'h400 + n), 1'b1, CAUSE_IBREAK, 2'(n));
      hit(mk(3'h3, 0, 32'h400 + n), 1'b0, CAUSE_IBREAK, 2'(n));
      hit(mk(3'h2, 0, 32'h500), 1'b0, CAUSE_IBREAK, 2'(n));
      wr(IDX_IB_CTRL + 8'(n), 32'h00040003);
      hit(mk(3'h2, 0, 32'h500), 1'b1, CAUSE_IBREAK, 2'(n));
      hit(mk(3'h2, 0, 32'h400 + n), 1'b0, CAUSE_IBREAK, 2'(n));
      wr(IDX_IB_CTRL + 8'(n), 32'h00040002);
      hit(mk(3'h2, 0, 32'h500), 1'b0, CAUSE_IBREAK, 2'(n));
    end
    for (int n = 1; n < 3; n++) wr(IDX_IB_ADDR + 8'(n), 32'h600);
    for (int n = 1; n < 3; n++) wr(IDX_IB_CTRL + 8'(n), 32'h00040001);
    hit(mk(3'h2, 0, 32'h600), 1'b1, CAUSE_IBREAK, 2'h1);
    for (int n = 1; n < 3; n++) wr(IDX_IB_CTRL + 8'(n), 32'h0);
    $display("test instruction breakpoints done");
  endtask
  task automatic t_dwatch();
    wr(IDX_DW_ADDR1 + 8'h1, 32'h1000);
    wr(IDX_DW_ADDR2 + 8'h1, 32'h2000);
    wr(IDX_DW_CTRL + 8'h1, 32'h00800001);
    hit(mk(3'h7, 1, 32'h1000), 1'b0, CAUSE_DWATCH, 2'h1);
    wr(IDX_DW_ADDR2 + 8'h1, 32'h1000);
    hit(mk(3'h7, 1, 32'h1000), 1'b1, CAUSE_DWATCH, 2'h1);
    wr(IDX_DW_ADDR2 + 8'h1, 32'h2000);
    wr(IDX_DW_CTRL + 8'h1, 32'h00800003);
    hit(mk(3'h7, 1, 32'h2000), 1'b1, CAUSE_DWATCH, 2'h1);
    chk_reg("trig_data", IDX_TRIG_DATA, 32'h2000);
    hit(mk(3'h7, 2, 32'h1000), 1'b0, CAUSE_DWATCH, 2'h1);
    wr(IDX_DW_CTRL + 8'h1, 32'h00800007);
    hit(mk(3'h7, 2, 32'h1000), 1'b1, CAUSE_DWATCH, 2'h1);
    chk_reg("trig_data", IDX_TRIG_DATA, 32'h1000);
    wr(IDX_DW_CTRL + 8'h1, 32'h0);
    $display("test data watchpoints done");
  endtask
  task automatic t_rwatch();
    wr(IDX_RW_MASK + 8'h3, 32'hFFFF0000);
    wr(IDX_RW_VALUE + 8'h3, 32'h12340000);
    wr(IDX_RW_CTRL + 8'h3, 32'h00010001);
    hit(mk(3'h0, 3, 32'h1234ABCD), 1'b1, CAUSE_RWATCH, 2'h3);
    chk_reg("trig_data", IDX_TRIG_DATA, 32'h1234ABCD);
    hit(mk(3'h0, 3, 32'h1235ABCD), 1'b0, CAUSE_RWATCH, 2'h3);
    wr(IDX_RW_CTRL + 8'h3, 32'h00010003);
    hit(mk(3'h0, 3, 32'h1235ABCD), 1'b1, CAUSE_RWATCH, 2'h3);
    hit(mk(3'h0, 3, 32'h12340000), 1'b0, CAUSE_RWATCH, 2'h3);
    wr(IDX_RW_CTRL + 8'h3, 32'h0);
    $display("test resource watchpoints done");
  endtask
  task automatic t_stop();
    wr(IDX_STOP_VEC, 32'hFFFFFF05);
    chk_reg("stop_reg", IDX_STOP_VEC, 32'h00000005);
    `CHK("stop", 8'h05, stop)
    wr(IDX_IB_ADDR, 32'h700);
    wr(IDX_IB_CTRL, 32'h00020001);
    i_dbw_core_model.set_mode(1'b1);
    @(posedge mclk_i);
    @(negedge mclk_i);
    `CHK("stop", 8'h00, stop)
    hit(mk(3'h1, 0, 32'h700), 1'b0, CAUSE_IBREAK, 2'h0);
    i_dbw_core_model.set_mode(1'b0);
    @(posedge mclk_i);
    @(negedge mclk_i);
    `CHK("stop", 8'h05, stop)
    hit(mk(3'h1, 0, 32'h700), 1'b1, CAUSE_IBREAK, 2'h0);
    $display("test stop vector done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_ibreak();
    t_dwatch();
    t_rwatch();
    t_stop();
    wrap_up();
  end
  // tests need well under a thousand cycles; this leaves ample margin
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
endmodule // dbw_tb_top
bind dbw_top dbw_chk i_dbw_chk(.mclk_i, .rst_n_i, .hreadyout_o, .hresp_o, .mon_i,
  .debug_mode_i, .dbg_irq_o, .trig_o, .thread_stop_o);
